//--- src/oas_addr_gen.sv
// Operand effective address and program space address generator.
`include "oas_regs.svh"
`default_nettype none

module oas_addr_gen #(
   parameter int DATA_W = 16,
   parameter int PROG_W = 24,
   parameter int NUM_WREGS = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire logic is_move,
   input wire logic is_file_op,
   input wire logic file_to_default_working_reg,
   input wire logic [`OAS_NEAR_ADDR_W-1:0] file_addr,
   input wire logic [DATA_W-1:0] move_file_addr,
   input wire oas_pkg::oas_mode_t src_mode,
   input wire oas_pkg::oas_mode_t dst_mode,
   input wire logic [3:0] src_ptr_sel,
   input wire logic [3:0] dst_ptr_sel,
   input wire logic [`OAS_OFFSET_FIELD_W-1:0] offset_sel,
   input wire logic post_decrement,
   input wire logic signed [DATA_W-1:0] pre_step,
   input wire logic [DATA_W-1:0] post_step,
   input wire logic [DATA_W-1:0] literal_offset,
   input wire logic [`OAS_SHORT_LIT_W-1:0] short_lit,
   input wire logic [`OAS_MOVE_LIT8_W-1:0] move_lit8,
   input wire logic [DATA_W-1:0] move_lit16,
   input wire logic move_lit_wide,
   input wire logic branch_take,
   input wire logic signed [`OAS_BRANCH_LIT_W-1:0] branch_lit,
   input wire logic hold_load,
   input wire logic [`OAS_HOLD_LIT_W-1:0] hold_lit,
   input wire logic pc_advance,
   input wire logic default_working_reg_we,
   input wire logic [3:0] default_working_reg_wsel,
   input wire logic [DATA_W-1:0] default_working_reg_wdata,
   input wire logic table_page_we,
   input wire logic [`OAS_PAGE_W-1:0] table_page_wdata,
   input wire logic visibility_page_we,
   input wire logic [`OAS_PAGE_W-1:0] visibility_page_wdata,
   input wire logic core_control_we,
   input wire logic [DATA_W-1:0] core_control_wdata,
   input wire oas_pkg::oas_tbl_t tbl_op,
   input wire logic tbl_byte_mode,
   input wire logic data_write,
   input wire logic [PROG_W-1:0] prog_rdata,
   output logic [DATA_W-1:0] src_ea,
   output logic [DATA_W-1:0] dst_ea,
   output logic [DATA_W-1:0] src_operand,
   output logic [DATA_W-1:0] first_operand,
   output logic [3:0] result_default_working_reg,
   output logic result_to_default_working_reg,
   output logic [PROG_W-1:0] prog_addr,
   output logic prog_rd,
   output logic prog_wr_low,
   output logic prog_wr_high,
   output logic cfg_space,
   output logic window_active,
   output logic window_write_err,
   output logic [DATA_W-1:0] read_data,
   output logic [PROG_W-1:0] pc,
   output logic [`OAS_HOLD_LIT_W-1:0] hold_count
);

   logic [DATA_W-1:0] default_working_reg_reg [NUM_WREGS];
   logic [`OAS_PAGE_W-1:0] table_page_reg;
   logic [`OAS_PAGE_W-1:0] visibility_page_reg;
   logic [DATA_W-1:0] core_control_reg;
   logic [PROG_W-1:0] pc_reg;
   logic [PROG_W-1:0] pc_next;
   logic [`OAS_HOLD_LIT_W-1:0] hold_reg;
   logic [DATA_W-1:0] ea_reg_s;
   logic [DATA_W-1:0] ea_reg_d;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [PROG_W-1:0] paddr_reg;
   logic [PROG_W-1:0] paddr_next;
   logic win_reg;
   logic cfg_reg;

   // Effective address for one operand; register sums share this decode.
   function automatic logic [DATA_W-1:0] ea_of(input oas_pkg::oas_mode_t mode,
                                                input logic [DATA_W-1:0] ptr,
                                                input logic [DATA_W-1:0] base,
                                                input logic signed [DATA_W-1:0] pre,
                                                input logic [DATA_W-1:0] lit);
      logic [DATA_W-1:0] r;
      r = ptr;
      unique case (mode)
         oas_pkg::OAS_PRE_MOD: r = ptr + DATA_W'(pre);
         oas_pkg::OAS_INDEXED: r = ptr + base;
         oas_pkg::OAS_LIT_OFFSET: r = ptr + lit;
         default: r = ptr;
      endcase
      return r;
   endfunction

   // Pointer value after a post-modified access.
   function automatic logic [DATA_W-1:0] post_of(input logic [DATA_W-1:0] ptr,
                                                 input logic dec,
                                                 input logic [DATA_W-1:0] step);
      return dec ? ptr - step : ptr + step;
   endfunction

   // Operand selection; the move shares one offset register for both ends.
   wire [DATA_W-1:0] src_ptr = default_working_reg_reg[src_ptr_sel];
   wire [DATA_W-1:0] dst_ptr = default_working_reg_reg[dst_ptr_sel];
   wire [DATA_W-1:0] base_operand_reg = default_working_reg_reg[offset_sel];
   wire [DATA_W-1:0] default_working_reg = default_working_reg_reg[`OAS_DEFAULT_DEFAULT_WORKING_REG];
   wire [DATA_W-1:0] near_addr = {{(DATA_W-`OAS_NEAR_ADDR_W){1'b0}}, file_addr};
   wire [DATA_W-1:0] file_ea = is_move ? move_file_addr : near_addr;
   wire [DATA_W-1:0] src_ea_w = is_file_op ? file_ea :
      ea_of(src_mode, src_ptr, base_operand_reg, pre_step, literal_offset);
   wire [DATA_W-1:0] dst_ea_w = is_file_op ? file_ea :
      ea_of(dst_mode, dst_ptr, base_operand_reg, pre_step, literal_offset);
   wire move_only_mode = (src_mode == oas_pkg::OAS_INDEXED) ||
      (src_mode == oas_pkg::OAS_LIT_OFFSET);
   wire [DATA_W-1:0] move_lit = move_lit_wide ? move_lit16 :
      {{(DATA_W-`OAS_MOVE_LIT8_W){1'b0}}, move_lit8};
   wire [DATA_W-1:0] short_ext = {{(DATA_W-`OAS_SHORT_LIT_W){1'b0}}, short_lit};
   wire [DATA_W-1:0] lit_operand = is_move ? move_lit : short_ext;
   wire src_is_lit = (src_mode == oas_pkg::OAS_LITERAL);
   wire src_is_direct = (src_mode == oas_pkg::OAS_DIRECT);

   // Write-back of pointer modes, as a two-port view of the register file.
   wire src_pre = op_valid && !is_file_op && (src_mode == oas_pkg::OAS_PRE_MOD);
   wire src_post = op_valid && !is_file_op && (src_mode == oas_pkg::OAS_POST_MOD);
   wire dst_pre = op_valid && !is_file_op && (dst_mode == oas_pkg::OAS_PRE_MOD);
   wire dst_post = op_valid && !is_file_op && (dst_mode == oas_pkg::OAS_POST_MOD);
   wire legal_mode = is_move || !move_only_mode;

   // Program window and table access decode.
   wire win_en = core_control_reg[`OAS_WINDOW_EN_BIT];
   wire tbl_any = (tbl_op != oas_pkg::OAS_TBL_NONE);
   wire win_hit = op_valid && !tbl_any && win_en && src_ea_w[`OAS_EA_WINDOW_BIT];
   wire [PROG_W-1:0] tbl_addr = {table_page_reg, src_ea_w};
   wire [PROG_W-1:0] win_addr = {1'b0, visibility_page_reg,
      src_ea_w[`OAS_EA_WINDOW_BIT-1:0]};
   wire byte_sel = src_ea_w[0];
   wire tbl_rd_low = op_valid && (tbl_op == oas_pkg::OAS_TBL_READ_LOW);
   wire tbl_rd_high = op_valid && (tbl_op == oas_pkg::OAS_TBL_READ_HIGH);
   wire [7:0] lo_byte = prog_rdata[7:0];
   wire [7:0] mid_byte = prog_rdata[15:8];
   wire [7:0] hi_byte = prog_rdata[PROG_W-1:16];

   // Read data steering from the addressed program word.
   always_comb begin
      rdata_next = rdata_reg;
      if (tbl_rd_low) begin
         if (tbl_byte_mode) begin
            rdata_next = {8'h00, byte_sel ? mid_byte : lo_byte};
         end else begin
            rdata_next = prog_rdata[15:0];
         end
      end else if (tbl_rd_high) begin
         if (tbl_byte_mode && byte_sel) begin
            rdata_next = 16'h0000;
         end else begin
            rdata_next = {8'h00, hi_byte};
         end
      end else if (win_hit && !data_write) begin
         rdata_next = prog_rdata[15:0];
      end
   end

   // Program address and counter next values.
   assign paddr_next = tbl_any ? tbl_addr : (win_hit ? win_addr : paddr_reg);
   assign pc_next = branch_take ? pc_reg + PROG_W'($signed({branch_lit, 1'b0})) :
      (pc_advance ? pc_reg + PROG_W'(`OAS_PC_STEP) : pc_reg);

   // Working registers: pointer updates win over ordinary writes to the same one.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_WREGS; i++) begin
            default_working_reg_reg[i] <= '0;
         end
      end else begin
         if (default_working_reg_we) begin
            default_working_reg_reg[default_working_reg_wsel] <= default_working_reg_wdata;
         end
         if (dst_post) begin
            default_working_reg_reg[dst_ptr_sel] <= post_of(dst_ptr, post_decrement, post_step);
         end
         if (dst_pre) begin
            default_working_reg_reg[dst_ptr_sel] <= dst_ea_w;
         end
         if (src_post) begin
            default_working_reg_reg[src_ptr_sel] <= post_of(src_ptr, post_decrement, post_step);
         end
         if (src_pre) begin
            default_working_reg_reg[src_ptr_sel] <= src_ea_w;
         end
      end
   end

   // Page, control, counter and captured access state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         table_page_reg <= `OAS_PAGE_RESET;
         visibility_page_reg <= `OAS_PAGE_RESET;
         core_control_reg <= `OAS_CTRL_RESET;
         pc_reg <= `OAS_PC_RESET;
         hold_reg <= '0;
         ea_reg_s <= '0;
         ea_reg_d <= '0;
         rdata_reg <= '0;
         paddr_reg <= '0;
         win_reg <= 1'b0;
         cfg_reg <= 1'b0;
      end else begin
         if (table_page_we) table_page_reg <= table_page_wdata;
         if (visibility_page_we) visibility_page_reg <= visibility_page_wdata;
         if (core_control_we) core_control_reg <= core_control_wdata;
         pc_reg <= pc_next;
         if (hold_load) hold_reg <= hold_lit;
         if (op_valid) ea_reg_s <= src_ea_w;
         if (op_valid) ea_reg_d <= dst_ea_w;
         rdata_reg <= rdata_next;
         paddr_reg <= paddr_next;
         win_reg <= win_hit;
         cfg_reg <= tbl_any ? table_page_reg[`OAS_PAGE_CFG_BIT] : 1'b0;
      end
   end

   // Operand and result routing.
   assign src_operand = src_is_lit ? lit_operand :
      (src_is_direct ? src_ptr : 16'h0000);
   assign first_operand = default_working_reg_reg[offset_sel];
   assign result_to_default_working_reg = is_file_op && file_to_default_working_reg;
   assign result_default_working_reg = `OAS_DEFAULT_DEFAULT_WORKING_REG;
   assign src_ea = legal_mode ? ea_reg_s : 16'h0000;
   assign dst_ea = ea_reg_d;
   assign prog_addr = paddr_next;
   assign prog_rd = (tbl_rd_low || tbl_rd_high) || (win_hit && !data_write);
   assign prog_wr_low = op_valid && (tbl_op == oas_pkg::OAS_TBL_WRITE_LOW);
   assign prog_wr_high = op_valid && (tbl_op == oas_pkg::OAS_TBL_WRITE_HIGH);
   assign window_write_err = win_hit && data_write;
   assign window_active = win_reg;
   assign cfg_space = cfg_reg;
   assign read_data = rdata_reg;
   assign pc = pc_reg;
   assign hold_count = hold_reg;

   // Checks.
   sequence s_win_req;
      win_hit && !data_write;
   endsequence
   property p_win_addr;
      @(posedge clk) disable iff (!rst_b) s_win_req |-> prog_addr[PROG_W-1] == 1'b0 &&
         prog_addr[15] == visibility_page_reg[0];
   endproperty
   a_win_addr: assert property (p_win_addr) else $error("window address wrong");
   property p_win_gate;
      @(posedge clk) disable iff (!rst_b) window_active |-> $past(win_en);
   endproperty
   a_win_gate: assert property (p_win_gate) else $error("window without enable");
   property p_tbl_addr;
      @(posedge clk) disable iff (!rst_b) (op_valid && tbl_any) |->
         prog_addr == {table_page_reg, src_ea_w};
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
   property p_rdh_word;
      @(posedge clk) disable iff (!rst_b) (tbl_rd_high && !tbl_byte_mode) |=>
         read_data == {8'h00, $past(prog_rdata[23:16])};
   endproperty
   a_rdh_word: assert property (p_rdh_word) else $error("read high wrong");
   property p_rdh_phantom;
      @(posedge clk) disable iff (!rst_b) (tbl_rd_high && tbl_byte_mode && byte_sel) |=>
         read_data == 16'h0000;
   endproperty
   a_rdh_phantom: assert property (p_rdh_phantom) else $error("phantom not zero");
   property p_rdl_word;
      @(posedge clk) disable iff (!rst_b) (tbl_rd_low && !tbl_byte_mode) |=>
         read_data == $past(prog_rdata[15:0]);
   endproperty
   a_rdl_word: assert property (p_rdl_word) else $error("read low wrong");
   property p_pc_step;
      @(posedge clk) disable iff (!rst_b) (pc_advance && !branch_take) |=>
         pc == $past(pc) + 24'h000002;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
   property p_indexed;
      @(posedge clk) disable iff (!rst_b) (op_valid && !is_file_op &&
         src_mode == oas_pkg::OAS_INDEXED && is_move) |=>
         src_ea == $past(src_ptr) + $past(base_operand_reg);
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");
   property p_near;
      @(posedge clk) disable iff (!rst_b) (op_valid && is_file_op && !is_move) |=>
         dst_ea[15:13] == 3'h0;
   endproperty
   a_near: assert property (p_near) else $error("near address too wide");
   sequence s_src_post;
      src_post;
   endsequence
   property p_post_ea;
      @(posedge clk) disable iff (!rst_b) s_src_post |=> src_ea == $past(src_ptr);
   endproperty
   a_post_ea: assert property (p_post_ea) else $error("post-modified address wrong");
   property p_post_step;
      @(posedge clk) disable iff (!rst_b) (s_src_post ##0 !post_decrement) |=>
         default_working_reg_reg[$past(src_ptr_sel)] == $past(src_ptr) + $past(post_step);
   endproperty
   a_post_step: assert property (p_post_step) else $error("pointer step wrong");
   sequence s_src_pre;
      src_pre;
   endsequence
   property p_pre_ea;
      @(posedge clk) disable iff (!rst_b) s_src_pre |=>
         src_ea == $past(src_ptr) + $past(pre_step);
   endproperty
   a_pre_ea: assert property (p_pre_ea) else $error("pre-modified address wrong");
   property p_pre_wb;
      @(posedge clk) disable iff (!rst_b) s_src_pre |=> default_working_reg_reg[$past(src_ptr_sel)] == src_ea;
   endproperty
   a_pre_wb: assert property (p_pre_wb) else $error("pre-modified pointer wrong");
   property p_lit_offset;
      @(posedge clk) disable iff (!rst_b) (op_valid && !is_file_op &&
         dst_mode == oas_pkg::OAS_LIT_OFFSET) |=>
         dst_ea == $past(dst_ptr) + $past(literal_offset);
   endproperty
   a_lit_offset: assert property (p_lit_offset) else $error("literal offset wrong");
   property p_win_refuse;
      @(posedge clk) disable iff (!rst_b) (win_hit && data_write) |->
         !prog_rd && !prog_wr_low && !prog_wr_high ##1 read_data == $past(read_data);
   endproperty
   a_win_refuse: assert property (p_win_refuse) else $error("window write not refused");
   property p_rdl_byte;
      @(posedge clk) disable iff (!rst_b) (tbl_rd_low && tbl_byte_mode) |=>
         read_data == {8'h00, $past(src_ea_w[0]) ? $past(prog_rdata[15:8]) :
         $past(prog_rdata[7:0])};
   endproperty
   a_rdl_byte: assert property (p_rdl_byte) else $error("byte read low wrong");
endmodule
`default_nettype wire

//--- src/oas_pkg.sv
// Types shared by the operand and program space address generator.
`default_nettype none
package oas_pkg;
   typedef enum logic [2:0] {
      OAS_DIRECT,
      OAS_INDIRECT,
      OAS_POST_MOD,
      OAS_PRE_MOD,
      OAS_INDEXED,
      OAS_LIT_OFFSET,
      OAS_LITERAL
   } oas_mode_t;
   typedef enum logic [2:0] {
      OAS_TBL_NONE,
      OAS_TBL_READ_LOW,
      OAS_TBL_READ_HIGH,
      OAS_TBL_WRITE_LOW,
      OAS_TBL_WRITE_HIGH
   } oas_tbl_t;
   typedef enum logic [1:0] {
      OAS_PH_IDLE,
      OAS_PH_BUSY
   } oas_phase_t;
endpackage
`default_nettype wire

//--- src/oas_regs.svh
// Constants for the operand and program space address generator.
`ifndef OAS_REGS_SVH
`define OAS_REGS_SVH
`define OAS_NEAR_ADDR_W 13
`define OAS_SHORT_LIT_W 5
`define OAS_OFFSET_FIELD_W 4
`define OAS_MOVE_LIT8_W 8
`define OAS_BRANCH_LIT_W 16
`define OAS_HOLD_LIT_W 14
`define OAS_PAGE_W 8
`define OAS_PAGE_CFG_BIT 7
`define OAS_EA_WINDOW_BIT 15
`define OAS_WINDOW_EN_BIT 2
`define OAS_PC_STEP 16'h0002
`define OAS_PC_RESET 24'h000000
`define OAS_PAGE_RESET 8'h00
`define OAS_CTRL_RESET 16'h0000
`define OAS_DEFAULT_DEFAULT_WORKING_REG 4'h0
`endif

//--- verification/oas_prog_mem.sv
// Behavioural program memory model answering table and window reads.
`default_nettype none
module oas_prog_mem (
   input wire logic [23:0] prog_addr,
   input wire logic prog_rd,
   output logic [23:0] prog_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] word;
   // Each location holds a pattern derived from its own address.
   assign word = {prog_addr[23:16] ^ prog_addr[7:0], ~prog_addr[15:0]};
   // Outside a read the lines show the inverse, so stale data never matches.
   assign prog_rdata = prog_rd ? word : ~word;
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the operand and program space address generator.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_b, op_valid, is_move, is_file_op, file_to_default_working_reg, post_decrement;
   logic move_lit_wide, branch_take, hold_load, pc_advance, default_working_reg_we, table_page_we;
   logic visibility_page_we, core_control_we, tbl_byte_mode, data_write;
   logic result_to_default_working_reg, prog_rd, prog_wr_low, prog_wr_high, cfg_space, window_active;
   logic window_write_err;
   logic [12:0] file_addr;
   logic [15:0] move_file_addr, post_step, literal_offset, move_lit16, default_working_reg_wdata;
   logic [15:0] core_control_wdata, src_ea, dst_ea, src_operand, first_operand, read_data;
   logic signed [15:0] pre_step, branch_lit;
   logic [3:0] src_ptr_sel, dst_ptr_sel, offset_sel, default_working_reg_wsel, result_default_working_reg;
   logic [4:0] short_lit;
   logic [7:0] move_lit8, table_page_wdata, visibility_page_wdata;
   logic [13:0] hold_lit, hold_count;
   logic [23:0] prog_rdata, prog_addr, pc;
   oas_pkg::oas_mode_t src_mode, dst_mode;
   oas_pkg::oas_tbl_t tbl_op;
   int n_errors, compares;
   typedef struct {
      oas_pkg::oas_tbl_t op;
      logic b;
      logic [7:0] page;
      logic [15:0] ea;
   } oas_row_t;
   oas_row_t rows [6] = '{
      '{oas_pkg::OAS_TBL_READ_LOW, 1'b0, 8'h12, 16'h3456},
      '{oas_pkg::OAS_TBL_READ_LOW, 1'b1, 8'h85, 16'h1235},
      '{oas_pkg::OAS_TBL_READ_LOW, 1'b1, 8'h00, 16'hBEEE},
      '{oas_pkg::OAS_TBL_READ_HIGH, 1'b0, 8'h7F, 16'h8001},
      '{oas_pkg::OAS_TBL_READ_HIGH, 1'b1, 8'h01, 16'h0011},
      '{oas_pkg::OAS_TBL_READ_HIGH, 1'b1, 8'h82, 16'hF010}};

   oas_addr_gen i_oas_addr_gen (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
      .is_move(is_move), .is_file_op(is_file_op), .file_to_default_working_reg(file_to_default_working_reg),
      .file_addr(file_addr), .move_file_addr(move_file_addr), .src_mode(src_mode),
      .dst_mode(dst_mode), .src_ptr_sel(src_ptr_sel), .dst_ptr_sel(dst_ptr_sel),
      .offset_sel(offset_sel), .post_decrement(post_decrement), .pre_step(pre_step),
      .post_step(post_step), .literal_offset(literal_offset), .short_lit(short_lit),
      .move_lit8(move_lit8), .move_lit16(move_lit16), .move_lit_wide(move_lit_wide),
      .branch_take(branch_take), .branch_lit(branch_lit), .hold_load(hold_load),
      .hold_lit(hold_lit), .pc_advance(pc_advance), .default_working_reg_we(default_working_reg_we),
      .default_working_reg_wsel(default_working_reg_wsel), .default_working_reg_wdata(default_working_reg_wdata), .table_page_we(table_page_we),
      .table_page_wdata(table_page_wdata), .visibility_page_we(visibility_page_we),
      .visibility_page_wdata(visibility_page_wdata), .core_control_we(core_control_we),
      .core_control_wdata(core_control_wdata), .tbl_op(tbl_op),
      .tbl_byte_mode(tbl_byte_mode), .data_write(data_write), .prog_rdata(prog_rdata),
      .src_ea(src_ea), .dst_ea(dst_ea), .src_operand(src_operand),
      .first_operand(first_operand), .result_default_working_reg(result_default_working_reg),
      .result_to_default_working_reg(result_to_default_working_reg), .prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_wr_low(prog_wr_low), .prog_wr_high(prog_wr_high), .cfg_space(cfg_space),
      .window_active(window_active), .window_write_err(window_write_err),
      .read_data(read_data), .pc(pc), .hold_count(hold_count));
   oas_prog_mem i_oas_prog_mem (.prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_rdata(prog_rdata));

   // Free-running 40 MHz clock.
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // Expected read data worked out from the memory pattern and the byte rules.
   function automatic logic [15:0] exp_rd(oas_row_t r);
      logic [23:0] p;
      p = {r.page ^ r.ea[7:0], ~r.ea};
      if (r.op == oas_pkg::OAS_TBL_READ_LOW)
         return r.b ? {8'h00, r.ea[0] ? p[15:8] : p[7:0]} : p[15:0];
      return (r.b && r.ea[0]) ? 16'h0000 : {8'h00, p[23:16]};
   endfunction

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc();
      @(posedge clk);
      #2;
   endtask

   // One edge takes the request, then every strobe drops.
   task automatic go();
      cyc();
      {op_valid, default_working_reg_we, table_page_we, visibility_page_we, core_control_we} = '0;
      {pc_advance, branch_take, hold_load} = '0;
   endtask

   task automatic w(input logic [3:0] sel, input logic [15:0] val);
      default_working_reg_we = 1'b1;
      default_working_reg_wsel = sel;
      default_working_reg_wdata = val;
      go();
      cyc();
   endtask

   task automatic test_done();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence: reset, table rows, then hand-written cases.
   initial begin
      rst_b = 1'b0;
      {op_valid, default_working_reg_we, table_page_we, visibility_page_we, core_control_we} = '0;
      {pc_advance, branch_take, hold_load, is_move, is_file_op, file_to_default_working_reg} = '0;
      {post_decrement, move_lit_wide, tbl_byte_mode, data_write, file_addr} = '0;
      {move_file_addr, post_step, literal_offset, move_lit16, default_working_reg_wdata} = '0;
      {core_control_wdata, pre_step, branch_lit, src_ptr_sel, dst_ptr_sel} = '0;
      {offset_sel, default_working_reg_wsel, short_lit, move_lit8, table_page_wdata} = '0;
      {visibility_page_wdata, hold_lit} = '0;
      src_mode = oas_pkg::OAS_INDIRECT;
      dst_mode = oas_pkg::OAS_INDIRECT;
      tbl_op = oas_pkg::OAS_TBL_NONE;
      repeat (10) @(posedge clk);
      #2;
      rst_b = 1'b1;
      chk(pc, 24'h000000);
      chk(hold_count, 14'h0000);
      chk({cfg_space, window_active}, 2'b00);
      $display("reset test done");
      // Window stays enabled so table rows with address bit 15 set prove it is off.
      core_control_we = 1'b1;
      core_control_wdata = 16'h0004;
      for (int i = 0; i < 6; i++) begin
         table_page_we = 1'b1;
         table_page_wdata = rows[i].page;
         w(4'h1, rows[i].ea);
         op_valid = 1'b1;
         tbl_op = rows[i].op;
         tbl_byte_mode = rows[i].b;
         src_ptr_sel = 4'h1;
         #1;
         chk(prog_addr, {rows[i].page, rows[i].ea});
         chk(prog_rd, 1'b1);
         go();
         chk(read_data, exp_rd(rows[i]));
         chk(cfg_space, rows[i].page[7]);
         chk(window_active, 1'b0);
         cyc();
      end
      $display("table rows done");
      // Window read, then a refused window write, then the window disabled.
      tbl_op = oas_pkg::OAS_TBL_NONE;
      visibility_page_we = 1'b1;
      visibility_page_wdata = 8'hA5;
      w(4'h2, 16'hC321);
      src_ptr_sel = 4'h2;
      op_valid = 1'b1;
      #1;
      chk(prog_addr, {1'b0, 8'hA5, 15'h4321});
      go();
      chk(window_active, 1'b1);
      chk(read_data, 16'h3CDE);
      cyc();
      data_write = 1'b1;
      op_valid = 1'b1;
      #1;
      chk({window_write_err, prog_rd, prog_wr_low, prog_wr_high}, 4'b1000);
      go();
      chk(read_data, 16'h3CDE);
      cyc();
      data_write = 1'b0;
      core_control_we = 1'b1;
      core_control_wdata = 16'h0000;
      go();
      cyc();
      op_valid = 1'b1;
      go();
      chk(window_active, 1'b0);
      $display("window test done");
      // Table writes raise only their own strobe.
      cyc();
      data_write = 1'b1;
      op_valid = 1'b1;
      tbl_op = oas_pkg::OAS_TBL_WRITE_HIGH;
      #1;
      chk({prog_wr_high, prog_wr_low, prog_rd}, 3'b100);
      go();
      cyc();
      op_valid = 1'b1;
      tbl_op = oas_pkg::OAS_TBL_WRITE_LOW;
      #1;
      chk({prog_wr_high, prog_wr_low, prog_rd}, 3'b010);
      go();
      {data_write, tbl_op} = '0;
      $display("table write test done");
      // Pointer modes, back to back post-increment first.
      cyc();
      w(4'h3, 16'h1000);
      w(4'h4, 16'h0020);
      src_mode = oas_pkg::OAS_POST_MOD;
      src_ptr_sel = 4'h3;
      post_step = 16'h0002;
      op_valid = 1'b1;
      cyc();
      chk(src_ea, 16'h1000);
      go();
      chk(src_ea, 16'h1002);
      post_decrement = 1'b1;
      cyc();
      op_valid = 1'b1;
      go();
      chk(src_ea, 16'h1004);
      src_mode = oas_pkg::OAS_PRE_MOD;
      pre_step = -16'sd4;
      cyc();
      op_valid = 1'b1;
      go();
      chk(src_ea, 16'h0FFE);
      cyc();
      w(4'h3, 16'h1000);
      is_move = 1'b1;
      src_mode = oas_pkg::OAS_INDEXED;
      dst_mode = oas_pkg::OAS_LIT_OFFSET;
      dst_ptr_sel = 4'h4;
      offset_sel = 4'h4;
      literal_offset = 16'h0100;
      op_valid = 1'b1;
      #1;
      chk(first_operand, 16'h0020);
      go();
      chk(src_ea, 16'h1020);
      chk(dst_ea, 16'h0120);
      cyc();
      is_move = 1'b0;
      op_valid = 1'b1;
      go();
      chk(src_ea, 16'h0000);
      $display("pointer mode test done");
      // Literals, register direct and file-register direct operands.
      cyc();
      src_mode = oas_pkg::OAS_LITERAL;
      short_lit = 5'h1F;
      #1;
      chk(src_operand, 16'h001F);
      is_move = 1'b1;
      move_lit8 = 8'hC8;
      #1;
      chk(src_operand, 16'h00C8);
      move_lit_wide = 1'b1;
      move_lit16 = 16'hBEEF;
      #1;
      chk(src_operand, 16'hBEEF);
      src_mode = oas_pkg::OAS_DIRECT;
      src_ptr_sel = 4'h4;
      #1;
      chk(src_operand, 16'h0020);
      move_file_addr = 16'hF123;
      is_file_op = 1'b1;
      op_valid = 1'b1;
      go();
      chk(src_ea, 16'hF123);
      is_move = 1'b0;
      file_addr = 13'h1ABC;
      file_to_default_working_reg = 1'b1;
      cyc();
      op_valid = 1'b1;
      #1;
      chk({result_to_default_working_reg, result_default_working_reg}, 5'h10);
      go();
      chk(src_ea, 16'h1ABC);
      file_to_default_working_reg = 1'b0;
      #1;
      chk(result_to_default_working_reg, 1'b0);
      $display("operand test done");
      // Program counter steps, a backward branch and the hold count.
      cyc();
      pc_advance = 1'b1;
      go();
      chk(pc, 24'h000002);
      cyc();
      branch_take = 1'b1;
      branch_lit = -16'sd3;
      hold_load = 1'b1;
      hold_lit = 14'h3FFF;
      go();
      chk(pc, 24'hFFFFFC);
      chk(hold_count, 14'h3FFF);
      $display("counter test done");
      // A second reset in mid-run clears the counters at once.
      rst_b = 1'b0;
      #3;
      chk(pc, 24'h000000);
      chk(hold_count, 14'h0000);
      cyc();
      rst_b = 1'b1;
      cyc();
      chk(pc, 24'h000000);
      pc_advance = 1'b1;
      go();
      chk(pc, 24'h000002);
      $display("mid-run reset test done");
      test_done();
   end
endmodule
`default_nettype wire
